// [bsl_top.sv]
/*
  Boot strap latch top: samples five strap pads once after system reset
  release, holds them, exposes them as status and decoded settings, and
  then hands the pads to their ordinary functions.
  Assumes the pad inputs are resolved levels synchronous to I_CLOCK and
  that I_RST_B covers power-on, watchdog and brownout resets.
*/
// What this block does
// - Sample all five strap pads when system reset is released.
// - Hold latched straps unchanged until power-down, ignoring pads.
// - Present the five latched strap bits as read-only status.
// - Enable each pad's weak default pull while reset is active.
// - After release the pads return to their ordinary function.
// - Supply strap 0 selects 3.3 V, 1 selects 1.8 V.
// - Boot pair both low selects serial download boot.
// - Two timing straps select slave sample and output edges.
// - Firmware may override supply select and slave timing.
// - Module enable high operates; low holds the block disabled.
`timescale 1ns/100ps
`default_nettype none
module bsl_top #(
  parameter int N_STRAP = bsl_pkg::BSL_NUM_STRAPS
) (
  // Clock, reset and enable.
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_MODULE_EN,
  // Strap pads: resolved level in, drive out, enable low drives.
  input wire logic [bsl_pkg::BSL_NUM_STRAPS-1:0] I_STRAP_PAD,
  output logic [bsl_pkg::BSL_NUM_STRAPS-1:0] O_PAD_OUT,
  output logic [bsl_pkg::BSL_NUM_STRAPS-1:0] O_PAD_OE_B,
  // Weak pull control.
  output logic [bsl_pkg::BSL_NUM_STRAPS-1:0] O_PULL_EN,
  output logic [bsl_pkg::BSL_NUM_STRAPS-1:0] O_PULL_UP,
  // Ordinary pad functions.
  input wire logic [bsl_pkg::BSL_NUM_STRAPS-1:0] I_FUNC_OUT,
  input wire logic [bsl_pkg::BSL_NUM_STRAPS-1:0] I_FUNC_OE_B,
  output logic [bsl_pkg::BSL_NUM_STRAPS-1:0] O_FUNC_IN,
  // Firmware overrides.
  input wire logic I_LDO_OVR_EN,
  input wire logic I_LDO_OVR_1V8,
  input wire logic I_SDIO_OVR_EN,
  input wire logic [1:0] I_SDIO_OVR_TIMING,
  // Status and decoded settings.
  output logic O_STRAP_VALID,
  output logic [bsl_pkg::BSL_NUM_STRAPS-1:0] O_STRAP_STATUS,
  output logic O_LDO_1V8,
  output logic O_BOOT_FLASH,
  output logic O_BOOT_DOWNLOAD,
  output logic O_BOOT_LOG_EN,
  output logic O_SDIO_SAMPLE_RISE,
  output logic O_SDIO_OUTPUT_RISE
);
  import bsl_pkg::*;

  bsl_state_t state_q;
  bsl_state_t state_d;
  logic valid_d;
  logic [N_STRAP-1:0] pull_en_d;
  logic capture;
  logic run;

  // Enable low acts as power-down, so a later rise captures afresh.
  always_comb begin
    state_d = state_q;
    case (state_q)
      BSL_ST_PULL: begin
        if (I_MODULE_EN) begin
          state_d = BSL_ST_RUN;
        end
      end
      BSL_ST_RUN: begin
        if (!I_MODULE_EN) begin
          state_d = BSL_ST_PULL;
        end
      end
      default: begin
        state_d = BSL_ST_PULL;
      end
    endcase
    valid_d = (state_d == BSL_ST_RUN);
    pull_en_d = valid_d ? BSL_ALL_ZERO : BSL_ALL_ONES;
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q <= BSL_ST_PULL;
      O_STRAP_VALID <= BSL_BIT_CLR;
      O_PULL_EN <= BSL_ALL_ONES;
      O_PULL_UP <= BSL_PULL_DIR;
    end else begin
      state_q <= state_d;
      O_STRAP_VALID <= valid_d;
      O_PULL_EN <= pull_en_d;
      O_PULL_UP <= BSL_PULL_DIR;
    end
  end

  // Capture happens only on the first enabled edge after release or after enable returns high.
  assign capture = I_MODULE_EN && (state_q == BSL_ST_PULL);
  assign run = I_MODULE_EN && (state_q == BSL_ST_RUN);

  for (genvar g = 0; g < N_STRAP; g++) begin : g_cell
    bsl_strap_cell u_cell (
      .i_clock(I_CLOCK),
      .i_rst_b(I_RST_B),
      .i_capture(capture),
      .i_run(run),
      .i_pad_in(I_STRAP_PAD[g]),
      .i_func_out(I_FUNC_OUT[g]),
      .i_func_oe_b(I_FUNC_OE_B[g]),
      .o_latch(O_STRAP_STATUS[g]),
      .o_pad_out(O_PAD_OUT[g]),
      .o_pad_oe_b(O_PAD_OE_B[g]),
      .o_func_in(O_FUNC_IN[g])
    );
  end

  bsl_decode u_decode (
    .i_clock(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_strap(O_STRAP_STATUS),
    .i_ldo_ovr_en(I_LDO_OVR_EN),
    .i_ldo_ovr_1v8(I_LDO_OVR_1V8),
    .i_sdio_ovr_en(I_SDIO_OVR_EN),
    .i_sdio_ovr_timing(I_SDIO_OVR_TIMING),
    .o_ldo_1v8(O_LDO_1V8),
    .o_boot_flash(O_BOOT_FLASH),
    .o_boot_download(O_BOOT_DOWNLOAD),
    .o_boot_log_en(O_BOOT_LOG_EN),
    .o_sdio_sample_rise(O_SDIO_SAMPLE_RISE),
    .o_sdio_output_rise(O_SDIO_OUTPUT_RISE)
  );

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);

  property p_capture;
    capture |=> (O_STRAP_STATUS == $past(I_STRAP_PAD)) && O_STRAP_VALID;
  endproperty
  a_capture: assert property (p_capture)
    else $error("Strap pads not captured at release.");

  property p_hold;
    (O_STRAP_VALID && I_MODULE_EN) [*2] |-> $stable(O_STRAP_STATUS);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Latched straps changed while running.");

  property p_status;
    $rose(O_STRAP_VALID) |-> O_STRAP_STATUS == $past(I_STRAP_PAD);
  endproperty
  a_status: assert property (p_status)
    else $error("Status does not show the captured pads.");

  property p_pull;
    !O_STRAP_VALID |-> (O_PULL_EN == BSL_ALL_ONES)
      && (O_PULL_UP == BSL_PULL_DIR);
  endproperty
  a_pull: assert property (p_pull)
    else $error("Weak pulls off before capture.");

  property p_func;
    run |=> (O_PAD_OE_B == $past(I_FUNC_OE_B))
      && (O_PAD_OUT == $past(I_FUNC_OUT))
      && (O_FUNC_IN == $past(I_STRAP_PAD));
  endproperty
  a_func: assert property (p_func)
    else $error("Pads not handed to ordinary function.");

  property p_ldo;
    (O_STRAP_VALID && !I_LDO_OVR_EN) |=>
      O_LDO_1V8 == $past(O_STRAP_STATUS[BSL_IDX_LDO]);
  endproperty
  a_ldo: assert property (p_ldo)
    else $error("Supply select does not follow strap.");

  property p_dl;
    O_STRAP_VALID |=> O_BOOT_DOWNLOAD ==
      ($past(O_STRAP_STATUS[BSL_IDX_BOOT2:BSL_IDX_BOOT1]) == 2'h0);
  endproperty
  a_dl: assert property (p_dl)
    else $error("Download boot decode wrong.");

  property p_flash;
    (O_STRAP_VALID && O_STRAP_STATUS[BSL_IDX_BOOT1]) |=>
      O_BOOT_FLASH && !O_BOOT_DOWNLOAD;
  endproperty
  a_flash: assert property (p_flash)
    else $error("Flash boot not selected.");

  property p_log;
    O_STRAP_VALID |=>
      O_BOOT_LOG_EN == $past(O_STRAP_STATUS[BSL_IDX_LOGTIM]);
  endproperty
  a_log: assert property (p_log)
    else $error("Boot log enable wrong.");

  property p_sdio;
    (O_STRAP_VALID && !I_SDIO_OVR_EN) |=>
      {O_SDIO_SAMPLE_RISE, O_SDIO_OUTPUT_RISE} ==
      {$past(O_STRAP_STATUS[BSL_IDX_LOGTIM]),
       $past(O_STRAP_STATUS[BSL_IDX_SDIOOUT])};
  endproperty
  a_sdio: assert property (p_sdio)
    else $error("Slave timing decode wrong.");

  property p_ovr;
    (I_LDO_OVR_EN && I_SDIO_OVR_EN) |=>
      (O_LDO_1V8 == $past(I_LDO_OVR_1V8))
      && ({O_SDIO_SAMPLE_RISE, O_SDIO_OUTPUT_RISE}
          == $past(I_SDIO_OVR_TIMING));
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("Firmware override not applied.");

  property p_en;
    !I_MODULE_EN |=> !O_STRAP_VALID && (O_PAD_OE_B == BSL_ALL_ONES)
      && (O_PULL_EN == BSL_ALL_ONES);
  endproperty
  a_en: assert property (p_en)
    else $error("Block active while enable is low.");

  // Until capture the pads stay released with their weak pulls on.
  property p_idle_pads;
    !O_STRAP_VALID |-> (O_PAD_OE_B == BSL_ALL_ONES)
      && (O_PAD_OUT == BSL_ALL_ZERO) && (O_FUNC_IN == BSL_ALL_ZERO);
  endproperty
  a_idle_pads: assert property (p_idle_pads)
    else $error("Pads leave the strap role before capture.");

  property p_pull_off;
    O_STRAP_VALID |-> (O_PULL_EN == BSL_ALL_ZERO);
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("Weak pulls still on after capture.");

  property p_pull_dir;
    O_PULL_UP == BSL_PULL_DIR;
  endproperty
  a_pull_dir: assert property (p_pull_dir)
    else $error("Weak pull direction wrong.");

  property p_valid_keep;
    (O_STRAP_VALID && I_MODULE_EN) |=> O_STRAP_VALID;
  endproperty
  a_valid_keep: assert property (p_valid_keep)
    else $error("Captured straps dropped while enabled.");

  property p_rise_en;
    $rose(O_STRAP_VALID) |-> $past(I_MODULE_EN);
  endproperty
  a_rise_en: assert property (p_rise_en)
    else $error("Straps captured while enable was low.");

  property p_en_func;
    !I_MODULE_EN |=> (O_FUNC_IN == BSL_ALL_ZERO)
      && (O_PAD_OUT == BSL_ALL_ZERO);
  endproperty
  a_en_func: assert property (p_en_func)
    else $error("Pad functions active while enable is low.");

  property p_no_flash;
    (O_STRAP_VALID && !O_STRAP_STATUS[BSL_IDX_BOOT1]) |=>
      !O_BOOT_FLASH;
  endproperty
  a_no_flash: assert property (p_no_flash)
    else $error("Flash boot selected with first boot strap low.");

  property p_no_dl;
    (O_STRAP_VALID && O_STRAP_STATUS[BSL_IDX_BOOT2]) |=>
      !O_BOOT_DOWNLOAD;
  endproperty
  a_no_dl: assert property (p_no_dl)
    else $error("Download boot selected with second boot strap high.");

  // Overrides act whether or not the straps have been captured.
  property p_ldo_ovr;
    I_LDO_OVR_EN |=> (O_LDO_1V8 == $past(I_LDO_OVR_1V8));
  endproperty
  a_ldo_ovr: assert property (p_ldo_ovr)
    else $error("Supply override not applied.");

  property p_sdio_ovr;
    I_SDIO_OVR_EN |=> ({O_SDIO_SAMPLE_RISE, O_SDIO_OUTPUT_RISE}
      == $past(I_SDIO_OVR_TIMING));
  endproperty
  a_sdio_ovr: assert property (p_sdio_ovr)
    else $error("Timing override not applied.");

  c_download: cover property (capture ##1
    O_STRAP_VALID ##1 O_BOOT_DOWNLOAD);
  c_flash: cover property (capture ##1 O_STRAP_VALID ##1 O_BOOT_FLASH);
  c_recapture: cover property (O_STRAP_VALID ##1 !I_MODULE_EN
    ##[1:20] capture);
  c_override: cover property (O_STRAP_VALID && I_SDIO_OVR_EN);
  c_log_on: cover property (capture ##2 O_BOOT_LOG_EN);
endmodule : bsl_top
`default_nettype wire

// [bsl_pkg.sv]
/*
  Shared constants for the boot strap latch: strap pin order, default
  pull directions, reset values and the top-level state type.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bsl_pkg;
  localparam int BSL_NUM_STRAPS = 5;
  // Strap pin positions in every strap vector.
  localparam int BSL_IDX_LDO = 0;
  localparam int BSL_IDX_BOOT1 = 1;
  localparam int BSL_IDX_BOOT2 = 2;
  localparam int BSL_IDX_LOGTIM = 3;
  localparam int BSL_IDX_SDIOOUT = 4;
  // Internal pull direction per strap, one means pull-up.
  localparam logic [BSL_NUM_STRAPS-1:0] BSL_PULL_DIR = 5'h1a;
  localparam logic [BSL_NUM_STRAPS-1:0] BSL_ALL_ONES = 5'h1f;
  localparam logic [BSL_NUM_STRAPS-1:0] BSL_ALL_ZERO = 5'h00;
  localparam logic BSL_BIT_CLR = 1'h0;
  localparam logic BSL_BIT_SET = 1'h1;
  // Level of the log strap that enables boot printing.
  localparam logic BSL_LOG_ON = 1'h1;
  // Level of the supply strap that selects the lower voltage.
  localparam logic BSL_LDO_LOW_V = 1'h1;
  typedef enum logic {BSL_ST_PULL, BSL_ST_RUN} bsl_state_t;
endpackage : bsl_pkg

// [bsl_strap_cell.sv]
/*
  One strap pin: the capture latch and the hand-over of the pad to its
  ordinary function once capture is done.
  Assumes the pad level is already resolved from pulls and drivers.
*/
`timescale 1ns/100ps
`default_nettype none
module bsl_strap_cell (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Control from the sequencer.
  input wire logic i_capture,
  input wire logic i_run,
  // Pad and ordinary function.
  input wire logic i_pad_in,
  input wire logic i_func_out,
  input wire logic i_func_oe_b,
  // Results.
  output logic o_latch,
  output logic o_pad_out,
  output logic o_pad_oe_b,
  output logic o_func_in
);
  import bsl_pkg::*;
  logic latch_d;
  logic out_d;
  logic oe_b_d;
  logic fin_d;

  always_comb begin
    latch_d = i_capture ? i_pad_in : o_latch;
    out_d = i_run ? i_func_out : BSL_BIT_CLR;
    oe_b_d = i_run ? i_func_oe_b : BSL_BIT_SET;
    fin_d = i_run ? i_pad_in : BSL_BIT_CLR;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_latch <= BSL_BIT_CLR;
      o_pad_out <= BSL_BIT_CLR;
      o_pad_oe_b <= BSL_BIT_SET;
      o_func_in <= BSL_BIT_CLR;
    end else begin
      o_latch <= latch_d;
      o_pad_out <= out_d;
      o_pad_oe_b <= oe_b_d;
      o_func_in <= fin_d;
    end
  end
endmodule : bsl_strap_cell
`default_nettype wire

// [bsl_decode.sv]
/*
  Decodes the latched strap bits into boot source, supply select, log
  enable and slave timing, with firmware overrides applied.
  Assumes the strap vector is stable once captured.
*/
`timescale 1ns/100ps
`default_nettype none
module bsl_decode (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Latched straps.
  input wire logic [bsl_pkg::BSL_NUM_STRAPS-1:0] i_strap,
  // Firmware overrides.
  input wire logic i_ldo_ovr_en,
  input wire logic i_ldo_ovr_1v8,
  input wire logic i_sdio_ovr_en,
  input wire logic [1:0] i_sdio_ovr_timing,
  // Decoded settings.
  output logic o_ldo_1v8,
  output logic o_boot_flash,
  output logic o_boot_download,
  output logic o_boot_log_en,
  output logic o_sdio_sample_rise,
  output logic o_sdio_output_rise
);
  import bsl_pkg::*;
  logic ldo_d;
  logic flash_d;
  logic dl_d;
  logic log_d;
  logic smp_d;
  logic outr_d;

  always_comb begin
    ldo_d = (i_strap[BSL_IDX_LDO] == BSL_LDO_LOW_V);
    flash_d = i_strap[BSL_IDX_BOOT1];
    dl_d = !i_strap[BSL_IDX_BOOT1]
           && !i_strap[BSL_IDX_BOOT2];
    log_d = (i_strap[BSL_IDX_LOGTIM] == BSL_LOG_ON);
    smp_d = i_strap[BSL_IDX_LOGTIM];
    outr_d = i_strap[BSL_IDX_SDIOOUT];
    if (i_ldo_ovr_en) begin
      ldo_d = i_ldo_ovr_1v8;
    end
    if (i_sdio_ovr_en) begin
      smp_d = i_sdio_ovr_timing[1];
      outr_d = i_sdio_ovr_timing[0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ldo_1v8 <= BSL_BIT_CLR;
      o_boot_flash <= BSL_BIT_CLR;
      o_boot_download <= BSL_BIT_CLR;
      o_boot_log_en <= BSL_BIT_CLR;
      o_sdio_sample_rise <= BSL_BIT_CLR;
      o_sdio_output_rise <= BSL_BIT_CLR;
    end else begin
      o_ldo_1v8 <= ldo_d;
      o_boot_flash <= flash_d;
      o_boot_download <= dl_d;
      o_boot_log_en <= log_d;
      o_sdio_sample_rise <= smp_d;
      o_sdio_output_rise <= outr_d;
    end
  end
endmodule : bsl_decode
`default_nettype wire

// [bsl_pad_model.sv]
/*
  Outside world of the strap pads: resistors or host pins that set a
  level, combined with the device's drive and weak pulls into one level.
  Assumes the bench commands which pads are driven from outside.
*/
`timescale 1ns/100ps
`default_nettype none
module bsl_pad_model (
  // Clock.
  input wire logic i_clock,
  // Outside drivers.
  input wire logic [4:0] i_ext_en,
  input wire logic [4:0] i_ext_val,
  // Device pad controls.
  input wire logic [4:0] i_pad_out,
  input wire logic [4:0] i_pad_oe_b,
  input wire logic [4:0] i_pull_en,
  input wire logic [4:0] i_pull_up,
  // Resolved level.
  output logic [4:0] o_pad
);
  logic [4:0] last_q = 5'h00;
  always_ff @(posedge i_clock) begin
    last_q <= o_pad;
  end
  // An undriven pad with no pull floats, shown as a toggling level.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (i_ext_en[i]) o_pad[i] = i_ext_val[i];
      else if (!i_pad_oe_b[i]) o_pad[i] = i_pad_out[i];
      else if (i_pull_en[i]) o_pad[i] = i_pull_up[i];
      else o_pad[i] = ~last_q[i];
    end
  end
endmodule : bsl_pad_model
`default_nettype wire

// [testbench.sv]
/*
  Self-checking bench for the boot strap latch: every strap value with
  random overrides, freeze, pad hand-over and enable recapture.
  Assumes bsl_pkg, bsl_top and bsl_pad_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  import bsl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic en = 1'b1;
  logic [4:0] ext_en = 5'h00, ext_val = 5'h00, fo = 5'h00, foe = 5'h1f;
  logic le = 1'b0, lv = 1'b0, se = 1'b0;
  logic [1:0] st = 2'h0;
  logic [4:0] pad, pout, poe, pen, pup, fin, stat, s;
  logic valid, ldo, fl, dl, lg, sr, orr;
  int checks = 0;
  int mismatches = 0;
  bsl_top i_bsl_top (.I_CLOCK(clk), .I_RST_B(rst_b), .I_MODULE_EN(en),
    .I_STRAP_PAD(pad), .O_PAD_OUT(pout), .O_PAD_OE_B(poe),
    .O_PULL_EN(pen), .O_PULL_UP(pup), .I_FUNC_OUT(fo), .I_FUNC_OE_B(foe),
    .O_FUNC_IN(fin), .I_LDO_OVR_EN(le), .I_LDO_OVR_1V8(lv),
    .I_SDIO_OVR_EN(se), .I_SDIO_OVR_TIMING(st), .O_STRAP_VALID(valid),
    .O_STRAP_STATUS(stat), .O_LDO_1V8(ldo), .O_BOOT_FLASH(fl),
    .O_BOOT_DOWNLOAD(dl), .O_BOOT_LOG_EN(lg), .O_SDIO_SAMPLE_RISE(sr),
    .O_SDIO_OUTPUT_RISE(orr));
  bsl_pad_model i_bsl_pad_model (.i_clock(clk), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .i_pad_out(pout), .i_pad_oe_b(poe),
    .i_pull_en(pen), .i_pull_up(pup), .o_pad(pad));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Expected {ldo, flash, download, log, sample, output} settings.
  function automatic logic [5:0] exp_dec(input logic [4:0] v);
    return {le ? lv : v[0], v[1], ~v[1] & ~v[2], v[3],
            se ? st[1] : v[3], se ? st[0] : v[4]};
  endfunction : exp_dec
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk_dec(input logic [4:0] v);
    `CHK("decode", exp_dec(v), {ldo, fl, dl, lg, sr, orr})
  endtask : chk_dec
  task automatic boot(input logic [4:0] m, input logic [4:0] v);
    @(negedge clk);
    rst_b = 1'b0;
    en = 1'b1;
    ext_en = m;
    ext_val = v;
    repeat (6) @(negedge clk);
    `CHK("rst_valid", 1'b0, valid)
    `CHK("rst_pull_en", BSL_ALL_ONES, pen)
    `CHK("rst_pull_up", BSL_PULL_DIR, pup)
    `CHK("rst_oe_b", BSL_ALL_ONES, poe)
    rst_b = 1'b1;
    @(negedge clk);
    `CHK("valid", 1'b1, valid)
    `CHK("status", (m & v) | (~m & BSL_PULL_DIR), stat)
    `CHK("pull_off", BSL_ALL_ZERO, pen)
    s = stat;
    @(negedge clk);
    chk_dec((m & v) | (~m & BSL_PULL_DIR));
  endtask : boot
  initial begin
    void'($urandom(90));
    boot(5'h00, 5'h00);
    $display("test default_pulls done");
    for (int i = 0; i < 32; i++) begin
      {le, lv, se, st} = 5'($urandom);
      boot(5'h1f, 5'(i));
      ext_val = ~s;
      fo = 5'($urandom);
      foe = 5'($urandom);
      {le, lv, se, st} = 5'($urandom);
      @(negedge clk);
      chk_dec(s);
      `CHK("pad_out", fo, pout)
      `CHK("pad_oe_b", foe, poe)
      @(negedge clk);
      `CHK("func_in", ~s, fin)
      `CHK("frozen", s, stat)
      chk_dec(s);
    end
    $display("test all_straps done");
    en = 1'b0;
    ext_val = 5'h05;
    @(negedge clk);
    `CHK("off_valid", 1'b0, valid)
    `CHK("off_pulls", BSL_ALL_ONES, pen)
    `CHK("off_oe_b", BSL_ALL_ONES, poe)
    `CHK("off_func_in", BSL_ALL_ZERO, fin)
    en = 1'b1;
    for (int n = 0; n < 8 && valid !== 1'b1; n++) @(negedge clk);
    if (valid !== 1'b1) begin
      mismatches++;
      $display("MISMATCH recapture_wait exp 1 got %b", valid);
    end else begin
      `CHK("recapture", 5'h05, stat)
    end
    $display("test enable_recapture done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
